/* rtl/cbt_defines.svh */
// Constants for the CAN interrupt, error-state and bit-timing block.
// How it works
// - Bit 13 reads transmitter bus-off state.
// - Bits 12, 11 read passive states.
// - Bits 10, 9 read warning states.
// - Bit 8 reads either warning state.
// - Bit 5 sets on new error state.
// - Bit 7 sets on invalid message.
// - Bit 6 sets on bus wake-up.
// - Bit 3 sets on FIFO almost full.
// - Bit 2 sets on receive overflow.
// - Bits 1, 0 set on buffer events.
// - Enable register mirrors flags, rest reads zero.
// - Error counters read as one word.
// - Jump width is field plus one quanta.
// - Quantum is two times prescaler plus one.
// - Bit 14 routes wake-up through filter.
// - Phase two length is field plus one.
// - Select bit picks programmed or derived length.
// - Bit 6 picks three samples or one.
// - Phase one length is field plus one.
// - Propagation length is field plus one.
`ifndef CBT_DEFINES_SVH
`define CBT_DEFINES_SVH

// ****************************************
// Register indices on the plain port
// ****************************************
`define CBT_IDX_FLAGS    3'h0
`define CBT_IDX_IRQ_EN   3'h1
`define CBT_IDX_ERR_CNT  3'h2
`define CBT_IDX_BT_CFG1  3'h3
`define CBT_IDX_BT_CFG2  3'h4

// ****************************************
// Field positions and masks
// ****************************************
`define CBT_F_INVALID    7
`define CBT_F_WAKE       6
`define CBT_F_ERROR      5
`define CBT_F_FIFO       3
`define CBT_F_RXOVF      2
`define CBT_F_RXBUF      1
`define CBT_F_TXBUF      0
`define CBT_FLAG_IMPL    8'hef
`define CBT_CFG2_MASK    16'h47ff
`define CBT_SJW_HI       7
`define CBT_SJW_LO       6
`define CBT_BRP_HI       5
`define CBT_BRP_LO       0
`define CBT_WFILT_BIT    14
`define CBT_PH2_HI       10
`define CBT_PH2_LO       8
`define CBT_PH2_SEL_BIT  7
`define CBT_TRIPLE_BIT   6
`define CBT_PH1_HI       5
`define CBT_PH1_LO       3
`define CBT_PROP_HI      2
`define CBT_PROP_LO      0

// ****************************************
// Reset values and timing counts
// ****************************************
`define CBT_ZERO8        8'h00
`define CBT_ZERO16       16'h0000
`define CBT_TQ_ONE       5'h01
`define CBT_IPT_TQ       5'h02
`define CBT_FILT_CYC     8'h04

`endif

/* rtl/cbt_pkg.sv */
// Types shared by the CAN interrupt, error-state and bit-timing block.
package cbt_pkg;

   // Bit-timing segment of the nominal bit.
   typedef enum logic [1:0] {
      CBT_SEG_SYNC  = 2'b00,
      CBT_SEG_TSEG1 = 2'b01,
      CBT_SEG_TSEG2 = 2'b10
   } cbt_seg_t;

   // Error states reported by the protocol engine.
   typedef struct packed {
      logic tx_bus_off_state;
      logic tx_error_passive_state;
      logic rx_error_passive_state;
      logic tx_warning_state;
      logic rx_warning_state;
   } cbt_err_state_t;

   // One-cycle event pulses from buffers and engine.
   typedef struct packed {
      logic invalid_msg;
      logic fifo_almost_full;
      logic rx_overflow;
      logic rx_buffer;
      logic tx_buffer;
   } cbt_evt_t;

   // Results of the bit timer.
   typedef struct packed {
      logic sample_bit;
      logic sample_valid;
      logic bit_start;
   } cbt_bt_out_t;

   // Whole state of the block.
   typedef struct packed {
      logic [7:0]  flags;
      logic [7:0]  en;
      logic [15:0] cnt;
      logic [7:0]  cfg1;
      logic [15:0] cfg2;
      logic [15:0] rdata;
      logic [5:0]  st_prev;
      logic [2:0]  rx_hist;
      logic        filt_line;
      logic [7:0]  filt_cnt;
      logic        wake_prev;
      logic        edge_prev;
      logic [6:0]  pre_cnt;
      cbt_seg_t    seg;
      logic [4:0]  seg_cnt;
      logic [4:0]  seg_len;
      logic        resync_done;
      cbt_bt_out_t bt;
      logic        irq;
   } cbt_state_t;

endpackage

/* rtl/cbt_core.sv */
// CAN interrupt flags, error-state status, counters and bit timer.
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "cbt_defines.svh"

module cbt_core #(
   parameter logic [7:0] FILT_CYC = `CBT_FILT_CYC
) (
   // Clock and reset.
   input  wire logic                    sys_clk,
   input  wire logic                    arst_n,
   // Register port.
   input  wire logic [2:0]              reg_addr,
   input  wire logic [15:0]             reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic [15:0]                  reg_rdata,
   // Protocol engine status and counters.
   input  wire cbt_pkg::cbt_err_state_t err_st,
   input  wire logic [7:0]              tx_error_counter,
   input  wire logic [7:0]              rx_error_counter,
   // Buffer and engine events.
   input  wire cbt_pkg::cbt_evt_t       evt,
   // Bus receive line from the transceiver.
   input  wire logic                    can_rx,
   // Bit timer results and interrupt.
   output cbt_pkg::cbt_bt_out_t         bt_out,
   output logic                         irq
);

   // ****************************************
   // Helpers
   // ****************************************

   // Smaller of two quanta counts.
   function automatic logic [4:0] cbt_min(
      input logic [4:0] a,
      input logic [4:0] b
   );
      cbt_min = (a < b) ? a : b;
   endfunction

   // Majority of three samples.
   function automatic logic cbt_maj(
      input logic [2:0] s
   );
      cbt_maj = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction

   // ****************************************
   // State
   // ****************************************

   cbt_pkg::cbt_state_t state_reg;   // Registered state.
   cbt_pkg::cbt_state_t state_next;  // Next state.

   logic [5:0]  status;     // Live error-state bits 13 down to 8.
   logic [15:0] flag_word;  // Flag register as software sees it.
   logic [7:0]  flag_set;   // Hardware set requests this cycle.
   logic        wake_src;   // Line seen by the wake-up detector.
   logic [4:0]  sjw_tq;     // Jump width in quanta.
   logic [4:0]  prop_tq;    // Propagation segment in quanta.
   logic [4:0]  ph1_tq;     // Phase one in quanta.
   logic [4:0]  ph2_prog;   // Programmed phase two in quanta.
   logic [4:0]  ph2_tq;     // Phase two actually used.
   logic [6:0]  pre_top;    // Last prescaler count of a quantum.
   logic        tq_tick;    // End of a time quantum.
   logic        rx_fall;    // Recessive to dominant edge.

   // ****************************************
   // Decoded fields
   // ****************************************

   // Status bits are taken live so software sees the engine now.
   always_comb begin
      status[5] = err_st.tx_bus_off_state;
      status[4] = err_st.tx_error_passive_state;
      status[3] = err_st.rx_error_passive_state;
      status[2] = err_st.tx_warning_state;
      status[1] = err_st.rx_warning_state;
      status[0] = err_st.tx_warning_state
                | err_st.rx_warning_state;
      flag_word = {2'b00, status, state_reg.flags};
   end

   // Timing fields are all field value plus one quantum.
   always_comb begin
      sjw_tq   = {3'b000, state_reg.cfg1[`CBT_SJW_HI:`CBT_SJW_LO]}
               + `CBT_TQ_ONE;
      prop_tq  = {2'b00, state_reg.cfg2[`CBT_PROP_HI:`CBT_PROP_LO]}
               + `CBT_TQ_ONE;
      ph1_tq   = {2'b00, state_reg.cfg2[`CBT_PH1_HI:`CBT_PH1_LO]}
               + `CBT_TQ_ONE;
      ph2_prog = {2'b00, state_reg.cfg2[`CBT_PH2_HI:`CBT_PH2_LO]}
               + `CBT_TQ_ONE;
      // Derived length never drops below the processing time.
      if (state_reg.cfg2[`CBT_PH2_SEL_BIT]) begin
         ph2_tq = ph2_prog;
      end else if (ph1_tq > `CBT_IPT_TQ) begin
         ph2_tq = ph1_tq;
      end else begin
         ph2_tq = `CBT_IPT_TQ;
      end
      // Quantum spans 2 x (prescaler + 1) clocks.
      pre_top = {state_reg.cfg1[`CBT_BRP_HI:`CBT_BRP_LO], 1'b1};
      // Wrap at or past the top so a smaller prescaler written in
      // mid-quantum never lets the counter run the long way round.
      tq_tick = (state_reg.pre_cnt >= pre_top);
   end

   // ****************************************
   // Event sources
   // ****************************************

   // Edges are judged on the raw line; the filter serves wake-up only.
   always_comb begin
      if (state_reg.cfg2[`CBT_WFILT_BIT]) begin
         wake_src = state_reg.filt_line;
      end else begin
         wake_src = can_rx;
      end
      rx_fall = state_reg.edge_prev & ~can_rx;
      flag_set                 = `CBT_ZERO8;
      flag_set[`CBT_F_INVALID] = evt.invalid_msg;
      flag_set[`CBT_F_WAKE]    = state_reg.wake_prev
                               & ~wake_src;
      flag_set[`CBT_F_ERROR]   = |(status
                               & ~state_reg.st_prev);
      flag_set[`CBT_F_FIFO]    = evt.fifo_almost_full;
      flag_set[`CBT_F_RXOVF]   = evt.rx_overflow;
      flag_set[`CBT_F_RXBUF]   = evt.rx_buffer;
      flag_set[`CBT_F_TXBUF]   = evt.tx_buffer;
   end

   // ****************************************
   // Next state
   // ****************************************

   // All register, flag, filter and timer updates in one place.
   always_comb begin
      state_next = state_reg;

      // Clear-only flags: a written 0 clears, a set in the same
      // cycle wins so no event is lost.
      if (reg_wr && reg_addr == `CBT_IDX_FLAGS) begin
         state_next.flags = state_reg.flags & reg_wdata[7:0];
      end
      state_next.flags = (state_next.flags | flag_set)
                       & `CBT_FLAG_IMPL;

      // Enable and timing registers; unused bits stay zero.
      if (reg_wr && reg_addr == `CBT_IDX_IRQ_EN) begin
         state_next.en = reg_wdata[7:0] & `CBT_FLAG_IMPL;
      end
      if (reg_wr && reg_addr == `CBT_IDX_BT_CFG1) begin
         state_next.cfg1 = reg_wdata[7:0];
      end
      if (reg_wr && reg_addr == `CBT_IDX_BT_CFG2) begin
         state_next.cfg2 = reg_wdata & `CBT_CFG2_MASK;
      end

      // Counters are copied each cycle from the engine.
      state_next.cnt = {tx_error_counter, rx_error_counter};

      // Read data stand only in the cycle after the strobe.
      state_next.rdata = `CBT_ZERO16;
      if (reg_rd) begin
         case (reg_addr)
            `CBT_IDX_FLAGS: begin
               state_next.rdata = flag_word;
            end
            `CBT_IDX_IRQ_EN: begin
               state_next.rdata = {`CBT_ZERO8, state_reg.en};
            end
            `CBT_IDX_ERR_CNT: begin
               state_next.rdata = state_reg.cnt;
            end
            `CBT_IDX_BT_CFG1: begin
               state_next.rdata = {`CBT_ZERO8, state_reg.cfg1};
            end
            `CBT_IDX_BT_CFG2: begin
               state_next.rdata = state_reg.cfg2;
            end
            default: begin
               state_next.rdata = `CBT_ZERO16;
            end
         endcase
      end

      // Edge history for error entry, wake-up and resync.
      state_next.st_prev   = status;
      state_next.wake_prev = wake_src;
      state_next.edge_prev = can_rx;
      state_next.rx_hist   = {state_reg.rx_hist[1:0], can_rx};

      // Line filter: a change must hold FILT_CYC clocks to pass,
      // which rejects glitches at the cost of wake-up latency.
      if (can_rx == state_reg.filt_line) begin
         state_next.filt_cnt = `CBT_ZERO8;
      end else if (state_reg.filt_cnt >= FILT_CYC - 8'h01) begin
         state_next.filt_line = can_rx;
         state_next.filt_cnt  = `CBT_ZERO8;
      end else begin
         state_next.filt_cnt = state_reg.filt_cnt + 8'h01;
      end

      // Interrupt request from any enabled flag.
      state_next.irq = |(state_reg.flags & state_reg.en);

      // Quantum prescaler.
      state_next.bt.sample_valid = 1'b0;
      state_next.bt.bit_start    = 1'b0;
      if (tq_tick) begin
         state_next.pre_cnt = 7'h00;
      end else begin
         state_next.pre_cnt = state_reg.pre_cnt + 7'h01;
      end

      // Bit timer: sync, then prop plus phase one, then phase two.
      case (state_reg.seg)
         cbt_pkg::CBT_SEG_SYNC: begin
            if (tq_tick) begin
               state_next.seg     = cbt_pkg::CBT_SEG_TSEG1;
               state_next.seg_cnt = 5'h00;
               state_next.seg_len = prop_tq + ph1_tq;
            end
         end
         cbt_pkg::CBT_SEG_TSEG1: begin
            if (rx_fall && !state_reg.resync_done) begin
               // Late edge: lengthen phase one by up to the jump.
               state_next.seg_len = state_reg.seg_len
                  + cbt_min(state_reg.seg_cnt + `CBT_TQ_ONE,
                            sjw_tq);
               state_next.resync_done = 1'b1;
            end else if (tq_tick) begin
               if (state_reg.seg_cnt + `CBT_TQ_ONE
                   >= state_reg.seg_len) begin
                  // Sample point.
                  state_next.bt.sample_valid = 1'b1;
                  if (state_reg.cfg2[`CBT_TRIPLE_BIT]) begin
                     state_next.bt.sample_bit =
                        cbt_maj(state_reg.rx_hist);
                  end else begin
                     state_next.bt.sample_bit =
                        state_reg.rx_hist[0];
                  end
                  state_next.seg     = cbt_pkg::CBT_SEG_TSEG2;
                  state_next.seg_cnt = 5'h00;
                  state_next.seg_len = ph2_tq;
               end else begin
                  state_next.seg_cnt = state_reg.seg_cnt
                                     + `CBT_TQ_ONE;
               end
            end
         end
         cbt_pkg::CBT_SEG_TSEG2: begin
            if (rx_fall && !state_reg.resync_done) begin
               // Early edge: shorten phase two by up to the jump.
               state_next.resync_done = 1'b1;
               if (state_reg.seg_len - state_reg.seg_cnt
                   <= sjw_tq) begin
                  state_next.seg          = cbt_pkg::CBT_SEG_TSEG1;
                  state_next.seg_cnt      = 5'h00;
                  state_next.seg_len      = prop_tq + ph1_tq;
                  state_next.pre_cnt      = 7'h00;
                  state_next.bt.bit_start = 1'b1;
               end else begin
                  state_next.seg_len = state_reg.seg_len
                                     - sjw_tq;
               end
            end else if (tq_tick) begin
               if (state_reg.seg_cnt + `CBT_TQ_ONE
                   >= state_reg.seg_len) begin
                  state_next.seg          = cbt_pkg::CBT_SEG_SYNC;
                  state_next.seg_cnt      = 5'h00;
                  state_next.resync_done  = 1'b0;
                  state_next.bt.bit_start = 1'b1;
               end else begin
                  state_next.seg_cnt = state_reg.seg_cnt
                                     + `CBT_TQ_ONE;
               end
            end
         end
         default: begin
            state_next.seg = cbt_pkg::CBT_SEG_SYNC;
         end
      endcase
      if (state_next.bt.bit_start) begin
         state_next.resync_done = 1'b0;
      end
   end

   // ****************************************
   // Registers
   // ****************************************

   // Flags, counters and enables clear at reset; the line filter
   // and edge history start recessive so reset is no wake-up.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg           <= '0;
         state_reg.filt_line <= 1'b1;
         state_reg.wake_prev <= 1'b1;
         state_reg.edge_prev <= 1'b1;
         state_reg.rx_hist   <= 3'b111;
         state_reg.seg       <= cbt_pkg::CBT_SEG_SYNC;
      end else begin
         state_reg <= state_next;
      end
   end

   assign reg_rdata = state_reg.rdata;
   assign bt_out    = state_reg.bt;
   assign irq       = state_reg.irq;

   // ****************************************
   // Assertions
   // ****************************************

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   a_rd_idle_zero: assert property (
      !reg_rd |=> reg_rdata == `CBT_ZERO16)
      else $error("read data not zero without read");

   a_bus_off_bit: assert property (
      reg_rd && reg_addr == `CBT_IDX_FLAGS
      |=> reg_rdata[13] == $past(err_st.tx_bus_off_state))
      else $error("bus-off bit wrong");

   a_any_warn_bit: assert property (
      reg_rd && reg_addr == `CBT_IDX_FLAGS
      |=> reg_rdata[8] == ($past(err_st.tx_warning_state)
                         | $past(err_st.rx_warning_state)))
      else $error("combined warning bit wrong");

   a_err_flag_set: assert property (
      |(status & ~state_reg.st_prev)
      |=> state_reg.flags[`CBT_F_ERROR])
      else $error("error flag not set on new state");

   a_invalid_set: assert property (
      evt.invalid_msg |=> state_reg.flags[`CBT_F_INVALID])
      else $error("invalid flag lost");

   a_en_reserved: assert property (
      reg_rd && reg_addr == `CBT_IDX_IRQ_EN
      |=> reg_rdata[15:8] == `CBT_ZERO8 && !reg_rdata[4])
      else $error("enable reserved bits not zero");

   a_cnt_read: assert property (
      reg_rd && reg_addr == `CBT_IDX_ERR_CNT
      |=> reg_rdata == {$past(tx_error_counter, 2),
                        $past(rx_error_counter, 2)})
      else $error("counter read wrong");

   a_irq_gate: assert property (
      ##1 irq == |($past(state_reg.flags) & $past(state_reg.en)))
      else $error("interrupt gate wrong");

   a_tq_bound: assert property (
      state_reg.pre_cnt <= pre_top || $changed(state_reg.cfg1))
      else $error("prescaler ran past quantum");

   a_ph2_entry: assert property (
      state_reg.seg == cbt_pkg::CBT_SEG_TSEG1
      && state_next.seg == cbt_pkg::CBT_SEG_TSEG2
      |=> state_reg.seg_len == $past(ph2_tq)
          && bt_out.sample_valid)
      else $error("phase two length wrong");

   a_jump_limit: assert property (
      state_reg.seg == cbt_pkg::CBT_SEG_TSEG1 && rx_fall
      && !state_reg.resync_done
      |=> state_reg.seg_len <= $past(state_reg.seg_len) + $past(sjw_tq))
      else $error("phase one stretched past jump width");

endmodule
`default_nettype wire

/* sim/cbt_bus_node.sv */
// Behavioural far-side bus node that drives the receive line.
`timescale 1ns/1ps
`default_nettype none

module cbt_bus_node (
   // Clock.
   input  wire logic sys_clk,
   // Bus receive line as seen through the transceiver.
   output var logic  can_rx
);
   // The line idles recessive, as a bus with no driver does.
   initial can_rx = 1'b1;

   // Pull the line dominant for n clocks, then let it go recessive.
   // Changes land just after an edge so the block never sees a race.
   task automatic dominant(input int n);
      @(posedge sys_clk);
      can_rx <= 1'b0;
      repeat (n) @(posedge sys_clk);
      can_rx <= 1'b1;
   endtask
endmodule
`default_nettype wire

/* sim/cbt_bench.sv */
// Self-checking bench for the CAN flag, error-state and bit-timing block.
`timescale 1ns/1ps
`default_nettype none

module can_irq_errstate_bit_timing_test;
   // ****************************************
   // Stimulus and observed signals
   // ****************************************
   logic                    sys_clk   = 1'b0;
   logic                    arst_n    = 1'b0;
   logic [2:0]              reg_addr  = 3'h0;
   logic [15:0]             reg_wdata = 16'h0000;
   logic                    reg_wr    = 1'b0;
   logic                    reg_rd    = 1'b0;
   logic [15:0]             reg_rdata;
   cbt_pkg::cbt_err_state_t err_st    = '0;
   logic [7:0]              tx_cnt    = 8'h00;
   logic [7:0]              rx_cnt    = 8'h00;
   cbt_pkg::cbt_evt_t       evt       = '0;
   wire logic               can_rx;
   cbt_pkg::cbt_bt_out_t    bt_out;
   logic                    irq;
   int                      n_fail    = 0;
   int                      tests_run = 0;
   int                      cycles    = 0;
   logic [15:0]             rv;

   // Free-running 100 MHz clock.
   always #5 sys_clk = ~sys_clk;

   cbt_core #(.FILT_CYC(8'h04)) uut (
      .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .err_st(err_st), .tx_error_counter(tx_cnt),
      .rx_error_counter(rx_cnt), .evt(evt), .can_rx(can_rx),
      .bt_out(bt_out), .irq(irq));

   cbt_bus_node node (.sys_clk(sys_clk), .can_rx(can_rx));

   // ****************************************
   // Shared tasks
   // ****************************************
   // Compare one value; case inequality so an unknown never matches.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One-cycle write strobe; the slave never stalls.
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe.
   task automatic rd(input logic [2:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // One-cycle event pulse from the buffer side.
   task automatic pulse(input cbt_pkg::cbt_evt_t e);
      @(posedge sys_clk);
      evt <= e;
      @(posedge sys_clk);
      evt <= '0;
   endtask

   // Clocks up to the next bit start, sampled on the falling edge.
   task automatic next_bs(output int n);
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (bt_out.bit_start !== 1'b1 && n < 3000);
   endtask

   // Clocks from a bit start to its sample point, on the falling edge.
   task automatic next_sv(output int n);
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (bt_out.sample_valid !== 1'b1 && n < 3000);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   // Every register reads zero after reset, unmapped index 5 too.
   task automatic t_reset();
      for (int i = 0; i < 6; i++) begin
         rd(i[2:0], rv); chk(rv, 16'h0000);
      end
      wr(3, 16'hffff); rd(3, rv); chk(rv, 16'h00ff);
      wr(4, 16'hffff); rd(4, rv); chk(rv, 16'h47ff);
      wr(5, 16'hffff); rd(5, rv); chk(rv, 16'h0000);
      $display("test reset done");
   endtask

   // Each status level shows live and its rise raises the error flag.
   task automatic t_status();
      logic [4:0] s;
      for (int i = 0; i < 5; i++) begin
         s = 5'b00001 << i;
         @(posedge sys_clk); err_st <= s;
         repeat (3) @(posedge sys_clk);
         rd(0, rv);
         chk(rv, {2'b00, s, |s[1:0], 8'h20});
         wr(0, 16'h0000);
         @(posedge sys_clk); err_st <= '0;
         repeat (3) @(posedge sys_clk);
         rd(0, rv); chk(rv, 16'h0000);
      end
      $display("test status done");
   endtask

   // Each event flag sets, survives a write of one, clears on zero.
   task automatic t_events();
      logic [7:0] b;
      wr(1, 16'hffff); rd(1, rv); chk(rv, 16'h00ef);
      for (int i = 0; i < 5; i++) begin
         b = (i == 4) ? 8'h80 : 8'h01 << i;
         wr(1, {8'h00, b});
         pulse(5'b00001 << i);
         rd(0, rv); chk(rv, {8'h00, b});
         chk({15'h0000, irq}, 16'h0001);
         wr(0, 16'hffff); rd(0, rv); chk(rv, {8'h00, b});
         wr(0, 16'h0000); repeat (2) @(posedge sys_clk);
         #1;
         chk({15'h0000, irq}, 16'h0000);
         rd(0, rv); chk(rv, 16'h0000);
      end
      wr(1, 16'h0000); pulse(5'b00001); repeat (2) @(posedge sys_clk);
      #1;
      chk({15'h0000, irq}, 16'h0000);
      wr(0, 16'h0000);
      $display("test events done");
   endtask

   // Counters read as one word and ignore writes.
   task automatic t_counters();
      @(posedge sys_clk); tx_cnt <= 8'ha5; rx_cnt <= 8'h3c;
      repeat (3) @(posedge sys_clk);
      rd(2, rv); chk(rv, 16'ha53c);
      wr(2, 16'h0000); rd(2, rv); chk(rv, 16'ha53c);
      $display("test counters done");
   endtask

   // A short glitch wakes only when the line filter is bypassed.
   task automatic t_wake();
      wr(4, 16'h0000); wr(0, 16'h0000);
      node.dominant(2); repeat (6) @(posedge sys_clk);
      rd(0, rv); chk(rv & 16'h0040, 16'h0040);
      wr(0, 16'h0000); wr(4, 16'h4000); wr(0, 16'h0000);
      node.dominant(2); repeat (10) @(posedge sys_clk);
      rd(0, rv); chk(rv & 16'h0040, 16'h0000);
      node.dominant(8); repeat (10) @(posedge sys_clk);
      rd(0, rv); chk(rv & 16'h0040, 16'h0040);
      wr(0, 16'h0000);
      $display("test wake done");
   endtask

   // Bit length in clocks is 2*(brp+1)*(1+prop+ph1+ph2) quanta.
   task automatic t_timer();
      logic [15:0] c1 [4] = '{16'h0000, 16'h0001, 16'h00c0, 16'h003f};
      logic [15:0] c2 [4] = '{16'h0000, 16'h038a, 16'h0027, 16'h0000};
      logic [15:0] ex [4] = '{16'h000a, 16'h0028, 16'h0026, 16'h0280};
      // Sample point lies (1+prop+ph1) quanta after the bit start.
      logic [15:0] sx [4] = '{16'h0006, 16'h0018, 16'h001c, 16'h0180};
      int n;
      for (int i = 0; i < 4; i++) begin
         wr(3, c1[i]); wr(4, c2[i]);
         next_bs(n); next_bs(n); next_bs(n);
         chk(n[15:0], ex[i]);
         next_sv(n);
         chk(n[15:0], sx[i]);
      end
      // A held dominant level samples 0 in single and triple mode.
      for (int i = 0; i < 2; i++) begin
         wr(3, 16'h0000); wr(4, i[0] ? 16'h0040 : 16'h0000);
         fork node.dominant(60); join_none
         repeat (40) @(negedge sys_clk);
         chk({15'h0000, bt_out.sample_bit}, 16'h0000);
         repeat (60) @(negedge sys_clk);
         chk({15'h0000, bt_out.sample_bit}, 16'h0001);
      end
      $display("test timer done");
   endtask

   // Counts, verdict and end of run.
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Hang guard: the tests need well under this many cycles.
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         n_fail = n_fail + 1;
         test_done();
      end
   end

   // Main sequence.
   initial begin
      repeat (6) @(posedge sys_clk);
      arst_n <= 1'b1;
      t_reset();
      t_status();
      t_events();
      t_counters();
      t_wake();
      t_timer();
      test_done();
   end
endmodule
`default_nettype wire
